// ===== logic/pmc_top.sv
`include "pmc_defs.svh"

module pmc_top
  import pmc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire pmc_ahb_req_type ahb_req,
  output pmc_ahb_rsp_type      ahb_rsp,
  input  wire logic            ext_clk,
  input  wire logic            khz_clk,
  input  wire logic            int_clk,
  output logic                 irq
);

  pmc_state_type st_reg;
  pmc_state_type st_next;

  logic        acc;
  logic [5:0]  idx;
  logic        src_level;
  logic        src_tick;
  logic [11:0] divisor;
  logic        pre_tick;
  logic        match;
  logic        wr_flag_clr;
  logic [1:0]  new_src;
  logic [2:0]  new_ps;
  logic        sc2_wr;

  // Prescaler ratio for the current source and code
  function automatic logic [11:0] pmc_divisor(input logic src_lo, input logic [2:0] ps);
    logic [11:0] d;
    d = 12'h001;
    if (!src_lo) begin
      unique case (ps)
        3'h1:    d = {1'b0, `PMC_DIV_B1};
        3'h2:    d = {1'b0, `PMC_DIV_B2};
        3'h3:    d = {1'b0, `PMC_DIV_B4};
        3'h4:    d = {1'b0, `PMC_DIV_B8};
        3'h5:    d = {1'b0, `PMC_DIV_B16};
        3'h6:    d = {1'b0, `PMC_DIV_B32};
        3'h7:    d = {1'b0, `PMC_DIV_B64};
        default: d = 12'h001;
      endcase
    end else begin
      unique case (ps)
        3'h1:    d = `PMC_DIV_H128;
        3'h2:    d = `PMC_DIV_H256;
        3'h3:    d = `PMC_DIV_H512;
        3'h4:    d = `PMC_DIV_H1024;
        3'h5:    d = `PMC_DIV_H2048;
        3'h6:    d = `PMC_DIV_H100;
        3'h7:    d = `PMC_DIV_H1000;
        default: d = 12'h001;
      endcase
    end
    return d;
  endfunction : pmc_divisor

  assign acc = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  assign idx = ahb_req.haddr[7:2];

  // Source selection; bus clock gives one tick per cycle
  always_comb begin
    unique case (st_reg.src)
      `PMC_SRC_EXT: src_level = ext_clk;
      `PMC_SRC_KHZ: src_level = khz_clk;
      `PMC_SRC_INT: src_level = int_clk;
      `PMC_SRC_BUS: src_level = 1'b1;
    endcase
  end

  assign src_tick = (st_reg.src == `PMC_SRC_BUS) ? 1'b1 : (src_level & ~st_reg.src_prev);
  assign divisor  = pmc_divisor(st_reg.src[0], st_reg.ps);
  assign pre_tick = (st_reg.ps != `PMC_PS_OFF) && src_tick &&
                    (st_reg.pre == divisor - 12'h001);
  assign match    = pre_tick && (st_reg.cnt == st_reg.mod_act);

  assign sc2_wr      = st_reg.wr_pend && (st_reg.wr_idx == `PMC_IDX_SRC_PRE);
  assign new_src     = ahb_req.hwdata[`PMC_SRC_MSB:`PMC_SRC_LSB];
  assign new_ps      = ahb_req.hwdata[`PMC_PS_MSB:`PMC_PS_LSB];
  assign wr_flag_clr = st_reg.wr_pend && (st_reg.wr_idx == `PMC_IDX_STATUS) &&
                       ahb_req.hwdata[`PMC_BIT_FLAG];

  always_comb begin
    st_next = st_reg;
    st_next.src_prev = src_level;

    // Prescaler and counter
    if (st_reg.ps != `PMC_PS_OFF && src_tick) begin
      if (pre_tick) begin
        st_next.pre = 12'h000;
      end else begin
        st_next.pre = st_reg.pre + 12'h001;
      end
    end
    if (pre_tick) begin
      if (match) begin
        st_next.cnt     = `PMC_CNT_RESET;
        st_next.mod_act = st_reg.mod_buf;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end

    // Data phase of a write
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_idx)
        `PMC_IDX_STATUS: begin
          st_next.irq_en = ahb_req.hwdata[`PMC_BIT_IRQ_EN];
        end
        `PMC_IDX_SRC_PRE: begin
          st_next.src = new_src;
          st_next.ps  = new_ps;
          if (new_src != st_reg.src) begin
            st_next.pre      = 12'h000;
            st_next.cnt      = `PMC_CNT_RESET;
            st_next.src_prev = 1'b1;
          end
          if (new_ps != st_reg.ps) begin
            st_next.pre = 12'h000;
            st_next.cnt = `PMC_CNT_RESET;
          end
          if (st_reg.ps == `PMC_PS_OFF && new_ps != `PMC_PS_OFF) begin
            st_next.mod_act = st_reg.mod_buf;
          end
        end
        `PMC_IDX_MOD_HIGH: st_next.mod_buf[15:8] = ahb_req.hwdata[7:0];
        `PMC_IDX_MOD_LOW:  st_next.mod_buf[7:0]  = ahb_req.hwdata[7:0];
        default: ;
      endcase
    end

    // Flag: a match in the clearing cycle keeps it set
    if (wr_flag_clr) begin
      st_next.flag = 1'b0;
    end
    if (match) begin
      st_next.flag = 1'b1;
    end

    // Address phase
    st_next.wr_pend = acc & ahb_req.hwrite;
    st_next.wr_idx  = idx;
    st_next.rdata   = 32'h0000_0000;
    if (acc && !ahb_req.hwrite) begin
      unique case (idx)
        `PMC_IDX_STATUS: begin
          st_next.rdata[`PMC_BIT_FLAG]   = st_reg.flag;
          st_next.rdata[`PMC_BIT_IRQ_EN] = st_reg.irq_en;
        end
        `PMC_IDX_SRC_PRE: begin
          st_next.rdata[7:0] = {st_reg.src, 3'h0, st_reg.ps};
        end
        `PMC_IDX_MOD_HIGH: st_next.rdata[7:0] = st_reg.mod_buf[15:8];
        `PMC_IDX_MOD_LOW:  st_next.rdata[7:0] = st_reg.mod_buf[7:0];
        `PMC_IDX_CNT_LOW: begin
          st_next.rdata[7:0] = st_reg.cnt[7:0];
          st_next.snap       = st_reg.cnt;
          st_next.snap_held  = 1'b1;
        end
        `PMC_IDX_CNT_HIGH: begin
          st_next.rdata[7:0] = st_reg.snap_held ? st_reg.snap[15:8] : st_reg.cnt[15:8];
          st_next.snap_held  = 1'b0;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.src       <= `PMC_SRC_RESET;
      st_reg.ps        <= `PMC_PS_RESET;
      st_reg.mod_buf   <= `PMC_MOD_RESET;
      st_reg.mod_act   <= `PMC_MOD_RESET;
      st_reg.cnt       <= `PMC_CNT_RESET;
      st_reg.src_prev  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ahb_rsp.hrdata    = st_reg.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  assign irq = st_reg.flag & st_reg.irq_en;

endmodule : pmc_top

// ===== logic/pmc_defs.svh
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register indices; byte address is four times the index
`define PMC_IDX_STATUS    6'h00
`define PMC_IDX_SRC_PRE   6'h01
`define PMC_IDX_MOD_HIGH  6'h02
`define PMC_IDX_MOD_LOW   6'h03
`define PMC_IDX_CNT_HIGH  6'h04
`define PMC_IDX_CNT_LOW   6'h05

// Field positions
`define PMC_BIT_FLAG      7
`define PMC_BIT_IRQ_EN    6
`define PMC_SRC_MSB       7
`define PMC_SRC_LSB       6
`define PMC_PS_MSB        2
`define PMC_PS_LSB        0

// Reset values
`define PMC_SRC_RESET     2'h0
`define PMC_PS_RESET      3'h0
`define PMC_MOD_RESET     16'h0000
`define PMC_CNT_RESET     16'h0000

// Source codes and the prescaler-off code
`define PMC_SRC_EXT       2'h0
`define PMC_SRC_KHZ       2'h1
`define PMC_SRC_INT       2'h2
`define PMC_SRC_BUS       2'h3
`define PMC_PS_OFF        3'h0

// Divide ratios, low source bit clear
`define PMC_DIV_B1        11'd1
`define PMC_DIV_B2        11'd2
`define PMC_DIV_B4        11'd4
`define PMC_DIV_B8        11'd8
`define PMC_DIV_B16       11'd16
`define PMC_DIV_B32       11'd32
`define PMC_DIV_B64       11'd64
// Divide ratios, low source bit set
`define PMC_DIV_H128      12'd128
`define PMC_DIV_H256      12'd256
`define PMC_DIV_H512      12'd512
`define PMC_DIV_H1024     12'd1024
`define PMC_DIV_H2048     12'd2048
`define PMC_DIV_H100      12'd100
`define PMC_DIV_H1000     12'd1000

`endif

// ===== logic/pmc_pkg.sv
package pmc_pkg;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pmc_ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pmc_ahb_rsp_type;

  typedef struct packed {
    logic        flag;
    logic        irq_en;
    logic [1:0]  src;
    logic [2:0]  ps;
    logic [15:0] mod_buf;
    logic [15:0] mod_act;
    logic [11:0] pre;
    logic [15:0] cnt;
    logic [15:0] snap;
    logic        snap_held;
    logic        src_prev;
    logic        wr_pend;
    logic [5:0]  wr_idx;
    logic [31:0] rdata;
  } pmc_state_type;

endpackage : pmc_pkg

// ===== tb/pmc_top_props.sv
module pmc_props
  import pmc_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire pmc_ahb_req_type ahb_req,
  input wire pmc_ahb_rsp_type ahb_rsp,
  input wire logic            ext_clk,
  input wire logic            khz_clk,
  input wire logic            int_clk,
  input wire logic            irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       rd, wr_reg, en_reg;
  logic [5:0] ix, ix_reg;
  logic [7:0] sp_reg, mh_reg, ml_reg, msel;
  logic [2:0] ps;
  assign rd = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & ~ahb_req.hwrite;
  assign ix = ahb_req.haddr[7:2];
  assign ps = sp_reg[2:0];
  assign msel = ix[0] ? ml_reg : mh_reg;
  // Shadow of what software wrote, updated at the data-phase edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {wr_reg, en_reg, ix_reg, sp_reg, mh_reg, ml_reg} <= '0;
    end else begin
      wr_reg <= ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & ahb_req.hwrite;
      ix_reg <= ix;
      if (wr_reg && ix_reg == 6'h00) en_reg <= ahb_req.hwdata[6];
      if (wr_reg && ix_reg == 6'h01) sp_reg <= ahb_req.hwdata[7:0] & 8'hc7;
      if (wr_reg && ix_reg == 6'h02) mh_reg <= ahb_req.hwdata[7:0];
      if (wr_reg && ix_reg == 6'h03) ml_reg <= ahb_req.hwdata[7:0];
    end
  end
  property p_bus_ok; ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  property p_idle_rd; !rd |=> ahb_rsp.hrdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside data phase");
  property p_src_rd; rd && ix == 6'h01 |=> ahb_rsp.hrdata == {24'h0, $past(sp_reg)}; endproperty
  a_src_rd: assert property (p_src_rd) else $error("source/prescale readback");
  property p_rsvd; rd && ix == 6'h01 |=> ahb_rsp.hrdata[5:3] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_mod_rd; rd && ix[5:1] == 5'h01 |=> ahb_rsp.hrdata[7:0] == $past(msel); endproperty
  a_mod_rd: assert property (p_mod_rd) else $error("modulo readback");
  property p_irq_en; irq |-> en_reg; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
  property p_irq_w1c; wr_reg && ix_reg == 6'h00 && ahb_req.hwdata[7] && ps == 3'h0 |=> !irq;
  endproperty
  a_irq_w1c: assert property (p_irq_w1c) else $error("flag not cleared");
  property p_ps_off; $rose(irq) && $past(en_reg) |-> $past(ps) != 3'h0; endproperty
  a_ps_off: assert property (p_ps_off) else $error("match while prescaler off");
  c_irq: cover property ($rose(irq));
  c_cnt_rd: cover property (rd && ix == 6'h05);
  c_clr: cover property ($fell(irq));
endmodule : pmc_props

// ===== tb/tb_periodic_match_counter.sv
module tb_periodic_match_counter
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk = 0, rst = 1, ext_clk = 0, khz_clk = 0, int_clk = 0, rph = 0;
  pmc_ahb_req_type req = '0;
  pmc_ahb_rsp_type rsp;
  logic            irq;
  logic [31:0]     lf = 32'h8aa2874b, q[$];
  logic [7:0]      v[4] = '{8'h01, 8'h41, 8'h81, 8'hff};
  int              n_errors = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  always @* req.hready = rsp.hreadyout;
  pmc_top i_dut (.clk(clk), .rst(rst), .ahb_req(req), .ahb_rsp(rsp), .ext_clk(ext_clk),
                 .khz_clk(khz_clk), .int_clk(int_clk), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Unselected sources carry noise that must not move the count
  always @(posedge clk) begin
    lf <= lfsr(lf);
    ext_clk <= lf[0];
    khz_clk <= lf[1];
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  always @(posedge clk) begin
    if (rph) chk("hrdata", q.pop_front(), rsp.hrdata);
    rph <= req.hsel & req.htrans[1] & ~req.hwrite & rsp.hreadyout;
  end
  task automatic summarize;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic hw;
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (rsp.hreadyout === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      summarize();
    end
  endtask : hw
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    req.hsel <= 1'b1;
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    req.haddr <= {24'h0, i, 2'h0};
    hw();
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    hw();
  endtask : bus
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(1'b0, i, 8'h0);
  endtask : rd
  task automatic ci(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : ci
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      int_clk <= 1'b1;
      repeat (2) @(posedge clk);
      int_clk <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : tick
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(i[5:0], 8'h00);
    $display("done: reset");
    wr(6'h00, 8'h40);
    wr(6'h01, 8'h81);
    tick(1);
    ci(1'b1);
    wr(6'h00, 8'h40);
    ci(1'b1);
    wr(6'h00, 8'hc0);
    ci(1'b0);
    tick(1);
    ci(1'b1);
    wr(6'h02, 8'h01);
    wr(6'h03, 8'h01);
    rd(6'h02, 8'h01);
    tick(1);
    wr(6'h00, 8'hc0);
    $display("done: modulo zero");
    tick(255);
    rd(6'h05, 8'hff);
    tick(1);
    rd(6'h04, 8'h00);
    rd(6'h05, 8'h00);
    rd(6'h04, 8'h01);
    tick(1);
    ci(1'b0);
    tick(1);
    ci(1'b1);
    rd(6'h05, 8'h00);
    $display("done: count and latch");
    tick(5);
    wr(6'h05, 8'h55);
    rd(6'h05, 8'h05);
    wr(6'h01, 8'h82);
    rd(6'h05, 8'h00);
    tick(4);
    rd(6'h05, 8'h02);
    wr(6'h01, 8'hc2);
    rd(6'h05, 8'h00);
    wr(6'h01, 8'hc6);
    repeat (1050) @(posedge clk);
    rd(6'h05, 8'h0a);
    wr(6'h01, 8'hc0);
    repeat (300) @(posedge clk);
    rd(6'h05, 8'h00);
    wr(6'h00, 8'hc0);
    ci(1'b0);
    $display("done: dividers");
    foreach (v[j]) begin
      wr(6'h01, v[j]);
      rd(6'h01, v[j] & 8'hc7);
    end
    wr(6'h06, 8'h5a);
    rd(6'h06, 8'h00);
    $display("done: fields");
    summarize();
  end
endmodule : tb_periodic_match_counter

bind pmc_top pmc_props i_props (.clk(clk), .rst(rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
  .ext_clk(ext_clk), .khz_clk(khz_clk), .int_clk(int_clk), .irq(irq));
